// ### design/srt_defines.svh
// offsets, field positions, reset values and timing counts of the read and write paths
`ifndef SRT_DEFINES_SVH
`define SRT_DEFINES_SVH

// ********************************
// register offsets
// ********************************
`define SRT_MODE_OFS 8'h00
`define SRT_STAT_OFS 8'h04
`define SRT_FLAG_OFS 8'h08
`define SRT_CNT_OFS 8'h0C

// ********************************
// mode register fields
// ********************************
`define SRT_BM_LO 0
`define SRT_BM_HI 1
`define SRT_RPRE2_BIT 2
`define SRT_WPRE2_BIT 3
`define SRT_CL_LO 4
`define SRT_CL_HI 8
`define SRT_AL_LO 9
`define SRT_AL_HI 13
`define SRT_CWL_LO 14
`define SRT_CWL_HI 18
`define SRT_PL_LO 19
`define SRT_PL_HI 22
`define SRT_PAR_BIT 23
`define SRT_MODE_RST 32'h0022_40B0

// ********************************
// flag register bits
// ********************************
`define SRT_SPACE_BIT 0
`define SRT_OVR_BIT 1

// ********************************
// timing counts in clocks
// ********************************
`define SRT_PAIRS_BURST 3'd4
`define SRT_PAIRS_CHOP 3'd2
`define SRT_CCD_MIN 4'd4
`define SRT_CCD_BAD_PRE2 4'd5
`define SRT_WPRE2_ADD 7'd1
`define SRT_DLY_DEPTH 128

`endif

// ### design/srt_pkg.sv
// types shared by the read burst and turnaround block
package srt_pkg;
    typedef enum logic [1:0] {
        SRT_BM_EIGHT = 2'b00,
        SRT_BM_OTF = 2'b01,
        SRT_BM_CHOP = 2'b10,
        SRT_BM_RSVD = 2'b11
    } srt_burst_mode_type;

    typedef enum logic [1:0] {
        SRT_CMD_DESELECT = 2'b00,
        SRT_CMD_READ = 2'b01,
        SRT_CMD_WRITE = 2'b10,
        SRT_CMD_OTHER = 2'b11
    } srt_cmd_type;
endpackage

// ### design/srt_delay_line.sv
// shift line that releases a tagged start a chosen number of clocks later
`timescale 1ns/100ps
module srt_delay_line #(
    parameter int W = 7,
    parameter int DEPTH = 128
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_tag,
    input wire logic [6:0] tap,
    output logic out_valid,
    output logic [W-1:0] out_tag
);
    logic [DEPTH-1:0] vld_q;
    logic [W-1:0] tag_q [DEPTH];
    wire [6:0] sel = (tap == 7'd0) ? 7'd0 : 7'(tap - 7'd1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vld_q <= '0;
        end else begin
            vld_q <= {vld_q[DEPTH-2:0], in_valid};
        end
    end

    // ********************************
    // tag stages
    // ********************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            if (g == 0) begin : g_first
                always_ff @(posedge core_clk) begin
                    tag_q[0] <= in_tag;
                end
            end else begin : g_rest
                always_ff @(posedge core_clk) begin
                    tag_q[g] <= tag_q[g-1];
                end
            end
        end
    endgenerate

    assign out_valid = vld_q[sel];
    assign out_tag = tag_q[sel];
endmodule

// ### design/srt_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module srt_pair_buf (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [31:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_data
);
    logic [31:0] slot_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = slot_q[rd_ptr_q];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end
endmodule

// ### design/srt_core.sv
// read burst, burst chop and turnaround logic with its register slave
// Functional notes
// - burst mode 00: every read is an eight-beat burst, select bit ignored
// - on-the-fly mode, select bit high at read: eight-beat burst
// - on-the-fly mode, select bit low: four-beat chop for that command
// - burst mode 10: every read and write is a four-beat chop
// - two-clock write preamble adds one clock: nine becomes ten
// - precharge bit low keeps bank open; high precharges after a read burst, writes never precharge
// - read latency is column plus additive plus parity latency
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "srt_defines.svh"
module srt_core (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire srt_pkg::srt_cmd_type cmd_kind,
    input wire logic burst_select_address_bit,
    input wire logic auto_precharge_address_bit,
    input wire logic [4:0] column_addr,
    input wire logic [31:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_data,
    output logic precharge_pulse
);
    import srt_pkg::*;

    // ********************************
    // mode register zero and flags
    // ********************************
    logic [31:0] mode_register_zero_q;
    logic [1:0] flag_q;
    logic [15:0] rd_count_q;
    srt_burst_mode_type burst_mode;
    assign burst_mode = srt_burst_mode_type'(
        mode_register_zero_q[`SRT_BM_HI:`SRT_BM_LO]);
    wire read_pre2 = mode_register_zero_q[`SRT_RPRE2_BIT];
    wire write_pre2 = mode_register_zero_q[`SRT_WPRE2_BIT];
    wire [6:0] column_latency =
        {2'b00, mode_register_zero_q[`SRT_CL_HI:`SRT_CL_LO]};
    wire [6:0] additive_latency =
        {2'b00, mode_register_zero_q[`SRT_AL_HI:`SRT_AL_LO]};
    wire [6:0] base_write_latency =
        {2'b00, mode_register_zero_q[`SRT_CWL_HI:`SRT_CWL_LO]};
    wire parity_on = mode_register_zero_q[`SRT_PAR_BIT];
    wire [6:0] parity_latency = parity_on ?
        {3'b000, mode_register_zero_q[`SRT_PL_HI:`SRT_PL_LO]} : 7'd0;

    // read latency adds parity latency only with parity on
    wire [6:0] read_latency =
        7'(column_latency + additive_latency + parity_latency);
    // two-clock write preamble adds one clock
    wire [6:0] pre_add = write_pre2 ? `SRT_WPRE2_ADD : 7'd0;
    // effective write latency
    wire [6:0] write_latency = 7'(base_write_latency + additive_latency
        + parity_latency + pre_add);

    // ********************************
    // burst length decoding
    // ********************************
    // fixed eight, fixed chop, or chop chosen per command
    function automatic logic is_chop(srt_burst_mode_type m, logic sel);
        logic c;
        c = 1'b0;
        unique case (m)
            SRT_BM_EIGHT: c = 1'b0;
            // select bit picks length per command
            SRT_BM_OTF: c = !sel;
            SRT_BM_CHOP: c = 1'b1;
            SRT_BM_RSVD: c = 1'b0;
        endcase
        return c;
    endfunction

    wire cmd_rd = (cmd_kind == SRT_CMD_READ);
    wire cmd_wr = (cmd_kind == SRT_CMD_WRITE);
    wire cmd_col = cmd_rd || cmd_wr;
    // chop applies to this command only
    wire cmd_chop = is_chop(burst_mode, burst_select_address_bit);
    wire [6:0] cmd_tag = {cmd_chop, auto_precharge_address_bit, column_addr};

    // ********************************
    // column command spacing watch
    // ********************************
    logic [3:0] gap_q;
    logic seen_q;
    // five-clock spacing flagged, not refused, under two-clock read preamble
    wire gap_bad = seen_q && ((gap_q < `SRT_CCD_MIN)
        || (read_pre2 && gap_q == `SRT_CCD_BAD_PRE2));
    wire space_err = cmd_col && gap_bad;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gap_q <= 4'd1;
            seen_q <= 1'b0;
        end else if (cmd_col) begin
            gap_q <= 4'd1;
            seen_q <= 1'b1;
        end else if (gap_q != 4'hF) begin
            gap_q <= 4'(gap_q + 4'd1);
        end
    end

    // ********************************
    // latency lines
    // ********************************
    logic rd_start;
    logic [6:0] rd_tag;
    logic wr_start;
    logic [6:0] wr_tag;

    srt_delay_line #(.W(7), .DEPTH(`SRT_DLY_DEPTH)) u_rd_line (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(cmd_rd),
        .in_tag(cmd_tag),
        .tap(read_latency),
        .out_valid(rd_start),
        .out_tag(rd_tag)
    );

    srt_delay_line #(.W(7), .DEPTH(`SRT_DLY_DEPTH)) u_wr_line (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(cmd_wr),
        .in_tag(cmd_tag),
        .tap(write_latency),
        .out_valid(wr_start),
        .out_tag(wr_tag)
    );

    // ********************************
    // data array
    // ********************************
    logic [31:0] mem_q [32];
    logic [2:0] rd_cnt_q;
    logic [4:0] rd_col_q;
    logic [1:0] rd_idx_q;
    logic rd_ap_q;
    logic [2:0] wr_cnt_q;
    logic [4:0] wr_col_q;
    logic [1:0] wr_idx_q;
    logic buf_ready;
    wire [4:0] rd_addr = {rd_col_q[4:2], 2'(rd_col_q[1:0] + rd_idx_q)};
    wire [4:0] wr_addr = {wr_col_q[4:2], 2'(wr_col_q[1:0] + wr_idx_q)};

    // ********************************
    // read burst engine
    // ********************************
    wire rd_push = (rd_cnt_q != 3'd0) && buf_ready;
    wire rd_busy = (rd_cnt_q > 3'd1) || (rd_cnt_q == 3'd1 && !rd_push);
    wire rd_load = rd_start && !rd_busy;
    wire overrun = rd_start && rd_busy;
    wire rd_last = rd_push && (rd_cnt_q == 3'd1);
    wire [2:0] rd_pairs = rd_tag[6] ? `SRT_PAIRS_CHOP : `SRT_PAIRS_BURST;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_cnt_q <= 3'd0;
            rd_col_q <= 5'd0;
            rd_idx_q <= 2'd0;
            rd_ap_q <= 1'b0;
        end else if (rd_load) begin
            rd_cnt_q <= rd_pairs;
            rd_col_q <= rd_tag[4:0];
            rd_idx_q <= 2'd0;
            rd_ap_q <= rd_tag[5];
        end else if (rd_push) begin
            // other commands only advance the running burst
            rd_cnt_q <= 3'(rd_cnt_q - 3'd1);
            rd_idx_q <= 2'(rd_idx_q + 2'd1);
        end
    end

    // precharge only after a burst with the bit high
    always_ff @(posedge core_clk) begin
        if (rst) begin
            precharge_pulse <= 1'b0;
        end else begin
            precharge_pulse <= rd_last && rd_ap_q;
        end
    end

    // ********************************
    // write burst engine
    // ********************************
    wire [2:0] wr_pairs = wr_tag[6] ? `SRT_PAIRS_CHOP : `SRT_PAIRS_BURST;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_cnt_q <= 3'd0;
            wr_col_q <= 5'd0;
            wr_idx_q <= 2'd0;
        end else if (wr_start) begin
            wr_cnt_q <= wr_pairs;
            wr_col_q <= wr_tag[4:0];
            wr_idx_q <= 2'd0;
        end else if (wr_cnt_q != 3'd0) begin
            wr_cnt_q <= 3'(wr_cnt_q - 3'd1);
            wr_idx_q <= 2'(wr_idx_q + 2'd1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_cnt_q != 3'd0) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    srt_pair_buf u_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(rd_push),
        .in_ready(buf_ready),
        .in_data(mem_q[rd_addr]),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    // ********************************
    // register slave
    // ********************************
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    wire take = hsel && hready && htrans[1];
    wire [7:0] ofs = {haddr[7:2], 2'b00};
    wire hit = (haddr[31:8] == 24'h00_0000);
    wire wr_mode = dp_wr_q && dp_addr_q == `SRT_MODE_OFS;
    wire wr_flag = dp_wr_q && dp_addr_q == `SRT_FLAG_OFS;
    wire [31:0] stat_w = {17'h0_0000, rd_busy || rd_cnt_q != 3'd0,
        write_latency, read_latency};
    wire [31:0] rd_mux =
        !hit ? 32'h0000_0000 :
        ofs == `SRT_MODE_OFS ? mode_register_zero_q :
        ofs == `SRT_STAT_OFS ? stat_w :
        ofs == `SRT_FLAG_OFS ? {30'h0000_0000, flag_q} :
        ofs == `SRT_CNT_OFS ? {16'h0000, rd_count_q} : 32'h0000_0000;
    wire [1:0] flag_set = {overrun, space_err};
    wire [1:0] flag_clr = wr_flag ? hwdata[1:0] : 2'b00;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            dp_wr_q <= take && hwrite && hit;
            dp_addr_q <= ofs;
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_register_zero_q <= `SRT_MODE_RST;
            flag_q <= 2'b00;
            rd_count_q <= 16'h0000;
        end else begin
            if (wr_mode) begin
                mode_register_zero_q <= hwdata;
            end
            // set wins over a write-one clear
            flag_q <= (flag_q & ~flag_clr) | flag_set;
            if (rd_load) begin
                rd_count_q <= 16'(rd_count_q + 16'd1);
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    fixed_eight_a: assert property (
        cmd_rd && burst_mode == SRT_BM_EIGHT |-> !cmd_tag[6])
        else $error("fixed mode produced a chop");
    otf_length_a: assert property (
        rd_load && !rd_tag[6] |=> rd_cnt_q == 3'd4
        ##1 rd_cnt_q == ($past(rd_push) ? 3'd3 : 3'd4))
        else $error("eight-beat burst not four pairs");
    chop_length_a: assert property (
        rd_load && rd_tag[6] |=> rd_cnt_q == 3'd2)
        else $error("chop not two pairs");
    fixed_chop_a: assert property (
        cmd_col && burst_mode == SRT_BM_CHOP |-> cmd_chop)
        else $error("fixed chop mode gave full burst");
    spacing_flag_a: assert property (
        cmd_col && seen_q && read_pre2 && gap_q == 4'd5
        |=> flag_q[`SRT_SPACE_BIT])
        else $error("five-clock spacing not flagged");
    wpre_latency_a: assert property (
        write_pre2 && base_write_latency == 7'd9 && additive_latency == 7'd0
        && !parity_on |-> write_latency == 7'd10)
        else $error("write latency not ten");
    read_latency_a: assert property (
        column_latency == 7'd11 && additive_latency == 7'd0 && parity_on
        && parity_latency == 7'd4 |-> read_latency == 7'd15)
        else $error("read latency not fifteen");
    precharge_a: assert property (
        precharge_pulse |-> $past(rd_ap_q) && $past(rd_cnt_q) == 3'd1)
        else $error("precharge without finished burst");
    no_disturb_a: assert property (
        rd_push && !rd_load && cmd_kind != SRT_CMD_READ
        |=> rd_cnt_q == 3'($past(rd_cnt_q) - 3'd1))
        else $error("burst disturbed by other command");
    stall_hold_a: assert property (
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("stalled word lost");
endmodule

// ### verif/srt_ctrl_model.sv
// controller model: column commands, write data and read collection
`timescale 1ns/100ps
module srt_ctrl_model (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic [6:0] wl,
    output srt_pkg::srt_cmd_type cmd_kind,
    output logic burst_select_address_bit,
    output logic auto_precharge_address_bit,
    output logic [4:0] column_addr,
    output logic [31:0] wr_data,
    output logic rd_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic precharge_pulse
);
    import srt_pkg::*;
    int cyc = 0;
    int n_pre = 0;
    int cmd_cyc = 0;
    int word_cyc[$];
    logic [31:0] words[$];

    initial begin
        cmd_kind = SRT_CMD_DESELECT;
        burst_select_address_bit = 1'b0;
        auto_precharge_address_bit = 1'b0;
        column_addr = 5'h00;
        wr_data = 32'h0000_0000;
        rd_ready = 1'b1;
    end

    // ****
    // receiver side and monitor
    // ****
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rd_ready <= !stall;
        if (rd_valid && rd_ready) begin
            words.push_back(rd_data);
            word_cyc.push_back(cyc);
        end
        if (precharge_pulse) n_pre++;
        if (cmd_kind == SRT_CMD_READ) cmd_cyc = cyc;
    end

    // idle mixes deselect and other commands
    task automatic idle();
        cmd_kind <= cyc[0] ? SRT_CMD_OTHER : SRT_CMD_DESELECT;
        column_addr <= ~column_addr;
        burst_select_address_bit <= ~burst_select_address_bit;
        auto_precharge_address_bit <= ~auto_precharge_address_bit;
    endtask

    // select and precharge bits go with the command
    task automatic col_cmd(input srt_cmd_type kind, input logic sel,
                           input logic ap, input logic [4:0] col,
                           input int gap);
        int k;
        @(posedge core_clk);
        cmd_kind <= kind;
        burst_select_address_bit <= sel;
        auto_precharge_address_bit <= ap;
        column_addr <= col;
        @(posedge core_clk);
        idle();
        // write pairs follow the effective write latency
        for (k = 1; k <= wl + 4 && kind == SRT_CMD_WRITE; k++) begin
            @(posedge core_clk);
            idle();
            if (k >= wl && k < wl + 4) begin
                wr_data <= 32'hA5A5_0000 + k - wl;
            end else begin
                wr_data <= ~wr_data;
            end
        end
        for (k = 2; k < gap; k++) begin
            @(posedge core_clk);
            idle();
        end
    endtask
endmodule

// ### verif/sdram_read_burst_turnaround_bench.sv
// self-checking bench for the read burst and turnaround block
`timescale 1ns/100ps
`include "srt_defines.svh"
module sdram_read_burst_turnaround_bench;
    import srt_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic stall = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [6:0] wl = 7'h0A;
    logic [31:0] hrdata, rd_data, wr_data, v;
    logic hreadyout, hresp, rd_valid, rd_ready, pre, sel, ap;
    logic [4:0] col;
    srt_cmd_type cmd_kind;
    int n_errors = 0;
    int tests_run = 0;
    int n_rd = 0;

    srt_core dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cmd_kind(cmd_kind),
        .burst_select_address_bit(sel), .auto_precharge_address_bit(ap),
        .column_addr(col), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .precharge_pulse(pre));

    srt_ctrl_model ctl_u (.core_clk(core_clk), .stall(stall), .wl(wl),
        .cmd_kind(cmd_kind), .burst_select_address_bit(sel),
        .auto_precharge_address_bit(ap), .column_addr(col),
        .wr_data(wr_data), .rd_ready(rd_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .precharge_pulse(pre));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ****
    // checking and closing
    // ****
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****
    // register bus master
    // ****
    task automatic hwait();
        int k;
        k = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && k < 64) begin
            @(posedge core_clk);
            k++;
        end
        if (k == 64) begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hwait();
        q = hrdata;
    endtask

    task automatic wreg(input logic [31:0] a, d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rreg(input logic [31:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0000_0000, q);
    endtask

    // mode word with column 11, additive 0, base write 9, parity 4
    function automatic logic [31:0] mode(input logic [1:0] bm,
                                         input logic rp2, wp2, par);
        return {8'h00, par, 4'h4, 5'd9, 5'd0, 5'd11, wp2, rp2, bm};
    endfunction

    // ****
    // read traffic
    // ****
    task automatic wait_words(input int n);
        int k;
        for (k = 0; k < 200 && ctl_u.words.size() < n; k++) begin
            @(posedge core_clk);
        end
        if (k == 200) begin
            n_errors++;
            stop_test();
        end
        repeat (8) @(posedge core_clk);
        check("word count", ctl_u.words.size(), n);
    endtask

    task automatic rd_burst(input logic [1:0] bm, input logic s, p,
                            input logic [4:0] c, input int n);
        int k;
        wreg(`SRT_MODE_OFS, mode(bm, 1'b0, 1'b0, 1'b0));
        ctl_u.words.delete();
        ctl_u.word_cyc.delete();
        ctl_u.n_pre = 0;
        ctl_u.col_cmd(SRT_CMD_READ, s, p, c, 2);
        n_rd++;
        wait_words(n);
        for (k = 0; k < n && k < ctl_u.words.size(); k++) begin
            check("read pair", ctl_u.words[k], 32'hA5A5_0000 + ((c + k) & 3));
        end
        if (ctl_u.words.size() > 0) begin
            check("first word delay", ctl_u.word_cyc[0] - ctl_u.cmd_cyc, 13);
        end
        check("precharge pulses", ctl_u.n_pre, p);
    endtask

    task automatic two_reads(input int gap);
        ctl_u.words.delete();
        ctl_u.col_cmd(SRT_CMD_READ, 1'b1, 1'b0, 5'd0, gap);
        ctl_u.col_cmd(SRT_CMD_READ, 1'b1, 1'b0, 5'd2, 2);
        n_rd += 2;
        wait_words(8);
        if (ctl_u.words.size() > 4) begin
            check("second burst", ctl_u.words[4], 32'hA5A5_0002);
        end
        rreg(`SRT_FLAG_OFS, v);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rreg(`SRT_MODE_OFS, v);
        check("mode reset", v, `SRT_MODE_RST);
        rreg(`SRT_FLAG_OFS, v);
        check("flags reset", v, 0);
        rreg(32'h0000_0010, v);
        check("unmapped read", v, 0);
        check("response", hresp, 0);
        $display("test reset done");

        wreg(`SRT_MODE_OFS, mode(2'b00, 1'b0, 1'b1, 1'b1));
        rreg(`SRT_STAT_OFS, v);
        check("read latency", v[6:0], 15);
        check("write latency", v[13:7], 14);
        wreg(`SRT_MODE_OFS, mode(2'b00, 1'b0, 1'b1, 1'b0));
        rreg(`SRT_STAT_OFS, v);
        check("read latency", v[6:0], 11);
        check("write latency", v[13:7], 10);
        ctl_u.col_cmd(SRT_CMD_WRITE, 1'b1, 1'b0, 5'd0, 2);
        $display("test latency done");

        rd_burst(2'b00, 1'b0, 1'b0, 5'd1, 4);
        rd_burst(2'b01, 1'b1, 1'b0, 5'd2, 4);
        rd_burst(2'b01, 1'b0, 1'b0, 5'd3, 2);
        rd_burst(2'b10, 1'b1, 1'b0, 5'd0, 2);
        rd_burst(2'b00, 1'b1, 1'b1, 5'd0, 4);
        rd_burst(2'b11, 1'b0, 1'b0, 5'd2, 4);
        $display("test bursts done");

        wreg(`SRT_MODE_OFS, mode(2'b00, 1'b1, 1'b0, 1'b0));
        two_reads(5);
        check("spacing flag", v, 32'h0000_0001);
        wreg(`SRT_FLAG_OFS, 32'h0000_0001);
        two_reads(6);
        check("spacing flag", v, 0);
        wreg(`SRT_MODE_OFS, mode(2'b00, 1'b0, 1'b0, 1'b0));
        two_reads(4);
        check("spacing flag", v, 0);
        $display("test spacing done");

        ctl_u.words.delete();
        stall <= 1'b1;
        ctl_u.col_cmd(SRT_CMD_READ, 1'b1, 1'b0, 5'd1, 4);
        // second read lands while the first is stalled: dropped
        ctl_u.col_cmd(SRT_CMD_READ, 1'b1, 1'b0, 5'd2, 2);
        n_rd++;
        repeat (24) @(posedge core_clk);
        check("stalled valid", rd_valid, 1);
        check("stalled data", rd_data, 32'hA5A5_0001);
        rreg(`SRT_STAT_OFS, v);
        check("busy", v[14], 1);
        stall <= 1'b0;
        wait_words(4);
        if (ctl_u.words.size() == 4) begin
            check("last after stall", ctl_u.words[3], 32'hA5A5_0000);
        end
        rreg(`SRT_CNT_OFS, v);
        check("burst count", v[15:0], n_rd[15:0]);
        rreg(`SRT_FLAG_OFS, v);
        check("overrun flag", v, 32'h0000_0002);
        $display("test stall done");
        stop_test();
    end
endmodule
